// [dau_chk.sv]
/*
 Port checker for the diagnostic alarm unit.
 Assumes it is bound to dau_top and runs in the mclk domain.
*/
`timescale 1ns/1ps
module dau_chk (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        startup,
  input wire logic        xfer_fail,
  input wire logic        incr_mode,
  input wire logic        amp_low,
  input wire logic        wr_req,
  input wire logic        lock_set,
  input wire logic [1:0]  wr_mode,
  input wire logic        wr_cpol,
  input wire logic        locked,
  input wire logic [14:0] flags,
  input wire logic [1:0]  if_mode,
  input wire logic        spi_cpol,
  input wire logic        irq_chipsel_pin_o,
  input wire logic        irq_chipsel_pin_oe,
  input wire logic        diag_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_wr;
    !locked && wr_req;
  endsequence
  sequence s_idle;
    !startup [*3];
  endsequence
  property p_lock_hold;
    locked |=> locked;
  endproperty
  property p_lock_set;
    s_wr ##0 lock_set |=> locked;
  endproperty
  property p_lock_cfg;
    locked && wr_req |=> $stable(if_mode) && $stable(spi_cpol);
  endproperty
  property p_mode;
    s_wr |=> if_mode == $past(wr_mode) && spi_cpol == $past(wr_cpol);
  endproperty
  property p_oe;
    1'b1 |-> irq_chipsel_pin_oe == if_mode[0];
  endproperty
  property p_irq_idle;
    flags == 15'h0000 |-> irq_chipsel_pin_o && !diag_active;
  endproperty
  property p_static;
    1'b1 |=> (flags & $past(flags) & dau_pkg::STATIC_MASK)
      == ($past(flags) & dau_pkg::STATIC_MASK);
  endproperty
  property p_proto_set;
    xfer_fail |=> flags[dau_pkg::F_PROTO];
  endproperty
  property p_proto_clr;
    !xfer_fail |=> !flags[dau_pkg::F_PROTO];
  endproperty
  property p_lowamp;
    amp_low && incr_mode |=> flags[dau_pkg::F_LOWAMP];
  endproperty
  property p_startup;
    s_idle |=> $stable(flags[7:6]);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lock released");
  a_lock_set: assert property (p_lock_set)
    else $error("lock not set");
  a_lock_cfg: assert property (p_lock_cfg)
    else $error("write taken while locked");
  a_mode: assert property (p_mode)
    else $error("config not taken");
  a_oe: assert property (p_oe)
    else $error("pin enable wrong for mode");
  a_irq_idle: assert property (p_irq_idle)
    else $error("irq active with no flag");
  a_static: assert property (p_static)
    else $error("static flag cleared");
  a_proto_set: assert property (p_proto_set)
    else $error("protocol flag missing");
  a_proto_clr: assert property (p_proto_clr)
    else $error("protocol flag stuck");
  a_lowamp: assert property (p_lowamp)
    else $error("low amplitude flag missing");
  a_startup: assert property (p_startup)
    else $error("memory flag moved after start-up");
endmodule

// [dau_host.sv]
/*
 Host model driving the decoded serial write port of the alarm unit.
 Assumes the bench calls wr and samples outputs at falling edges.
*/
`timescale 1ns/1ps
module dau_host (
  input  wire logic        mclk,
  output logic             wr_req,
  output logic             lock_set,
  output logic [14:0]      wr_irq_en,
  output logic             wr_diag_en,
  output logic             wr_diag_lvl,
  output logic [15:0]      wr_tb_hi,
  output logic [15:0]      wr_tb_lo,
  output logic [15:0]      wr_wdog,
  output logic [1:0]       wr_mode,
  output logic             wr_cpol,
  output logic             wr_cpha,
  output logic             wr_lsb_first
);
  initial begin
    {wr_req, lock_set, wr_irq_en, wr_diag_en, wr_diag_lvl} = '0;
    {wr_tb_hi, wr_tb_lo, wr_wdog, wr_mode} = '0;
    {wr_cpol, wr_cpha, wr_lsb_first} = '0;
  end
  // One whole-word write; mode, enable and lock fields are scrambled once the strobe drops.
  task automatic wr(input logic [1:0] m, input logic [14:0] en,
                    input logic [15:0] wd, input logic [15:0] lo,
                    input logic lk);
    @(negedge mclk);
    wr_mode = m;
    wr_irq_en = en;
    wr_wdog = wd;
    wr_tb_lo = lo;
    wr_tb_hi = 16'hffff;
    lock_set = lk;
    wr_diag_en = 1'b1;
    wr_diag_lvl = m[0];
    {wr_cpha, wr_cpol} = m;
    wr_lsb_first = ^m;
    wr_req = 1'b1;
    @(negedge mclk);
    wr_req = 1'b0;
    wr_mode = ~wr_mode;
    wr_irq_en = ~wr_irq_en;
    lock_set = ~lock_set;
  endtask
endmodule

// [dau_pkg.sv]
/*
 Constants for the diagnostic alarm unit: flag indices, flag classes,
 interface modes and timing. Assumes a single 125 MHz clock domain.
*/
// Overview of operation
// - Once the lock bit is set, every serial write is ignored.
// - Each flag has an enable deciding whether it raises an interrupt.
// - Interrupts may optionally drive the four sine/cosine pins diagnostic.
// - Diagnostic output signalling is enabled per config, driving low or high.
// - Static flags stay set until power-on reset.
// - Temporary flags clear as soon as their fault disappears.
// - Continuous flags always evaluated; start-up flags only during start-up.
// - Supply over-voltage flag from hysteresis comparator, temporary.
// - Supply under-voltage flag from hysteresis comparator, temporary.
// - Protocol integrity flag raised when a serial transfer fails.
// - Shadow register double-bit error raises a static flag.
// - Shadow single-bit error raises temporary flag and corrects the bit.
// - Start-up memory word double-bit error raises a static flag.
// - Start-up memory single-bit error raises temporary flag, word corrected.
// - Time base counter measures oscillator; flag when outside limits.
// - Temporary flag when the transmitter oscillator stops.
// - Shared flag for analog supply low or pin over-voltage.
// - Low amplitude flag in incremental mode below minimum gain.
// - Nonzero watchdog value runs counter; expiry sets static flag, restarts.
// - Crack detector raises a static flag on mechanical damage.
// - Serial interface has four selectable modes.
// - SPI polarity, phase and bit order are configurable.
// - In interrupt modes the shared pin is a push-pull interrupt output.
package dau_pkg;
  localparam int NFLAG = 15;
  localparam int F_OVERV = 0;
  localparam int F_UNDERV = 1;
  localparam int F_ACCESS = 2;
  localparam int F_PROTO = 3;
  localparam int F_SHD_DBL = 4;
  localparam int F_SHD_SGL = 5;
  localparam int F_NVM_DBL = 6;
  localparam int F_NVM_SGL = 7;
  localparam int F_OSC_RANGE = 8;
  localparam int F_OSC_STUCK = 9;
  localparam int F_ANALOG = 10;
  localparam int F_LOWAMP = 11;
  localparam int F_INTBUS = 12;
  localparam int F_WDOG = 13;
  localparam int F_CRACK = 14;
  // Bit set means static (held until power-on reset).
  localparam logic [14:0] STATIC_MASK = 15'h6050;
  // Bit set means evaluated during start-up only.
  localparam logic [14:0] STARTUP_MASK = 15'h00c0;
  localparam logic [14:0] FLAGS_RST = 15'h0000;
  typedef enum logic [1:0] {
    dau_spi_half,
    dau_spi_irq,
    dau_i2c_addr,
    dau_i2c_irq
  } dau_mode_t;
  localparam int OSC_TIMEOUT_NS = 2000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_TIMEOUT_CYC = OSC_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [15:0] TB_RST = 16'h0000;
endpackage

// [dau_secded.sv]
/*
 Single-error-correct, double-error-detect check of one Hamming
 coded word (8 data bits, 5 check bits). Combinational decode with
 registered outputs. Assumes mclk domain.
*/
`timescale 1ns/1ps
module dau_secded (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        check,
  input  wire logic [12:0] code,
  output logic      [7:0]  data,
  output logic             single_err,
  output logic             double_err
);
  logic [3:0]  syn;
  logic        par;
  logic [12:0] fixed;
  always_comb begin
    syn = '0;
    for (int i = 1; i < 13; i++) begin
      if (code[i]) begin
        syn = syn ^ 4'(i);
      end
    end
    par = ^code;
    fixed = code;
    if (par && syn != 4'h0 && syn < 4'hd) begin
      fixed[syn] = ~code[syn];
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data <= 8'h00;
      single_err <= 1'b0;
      double_err <= 1'b0;
    end else if (check) begin
      data <= {fixed[12:9], fixed[7:5], fixed[3]};
      single_err <= par;
      double_err <= !par && syn != 4'h0;
    end
  end
endmodule

// [dau_sync.sv]
/*
 Three-stage synchroniser for an asynchronous level; change is
 accepted when stages two and three agree. Assumes mclk domain.
*/
`timescale 1ns/1ps
module dau_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  for (genvar i = 0; i < W; i++) begin : g_agree
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        dout[i] <= 1'b0;
      end else if (s2[i] == s3[i]) begin
        dout[i] <= s3[i];
      end
    end
  end
endmodule

// [dau_top.sv]
/*
 Diagnostic alarm unit: gathers fault sources, classifies them as
 static or temporary, drives the interrupt pin and the diagnostic
 state of the sine/cosine outputs, runs the watchdog and oscillator
 monitors and gates serial writes with the lock. Assumes a serial
 slave outside that presents decoded writes and transfer errors.
*/
`timescale 1ns/1ps
module dau_top #(
  parameter int TB_W = 16,
  parameter int WD_W = 16
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             startup,
  input  wire logic             cmp_overv,
  input  wire logic             cmp_underv,
  input  wire logic             access_fail,
  input  wire logic             xfer_fail,
  input  wire logic [12:0]      shadow_code,
  input  wire logic [12:0]      nvm_code,
  input  wire logic             nvm_valid,
  input  wire logic             osc_in,
  input  wire logic [TB_W-1:0]  tb_window,
  input  wire logic             analog_low,
  input  wire logic             pin_overv,
  input  wire logic             incr_mode,
  input  wire logic             amp_low,
  input  wire logic             intbus_fail,
  input  wire logic             crack,
  input  wire logic             wr_req,
  input  wire logic             lock_set,
  input  wire logic [14:0]      wr_irq_en,
  input  wire logic             wr_diag_en,
  input  wire logic             wr_diag_lvl,
  input  wire logic [TB_W-1:0]  wr_tb_hi,
  input  wire logic [TB_W-1:0]  wr_tb_lo,
  input  wire logic [WD_W-1:0]  wr_wdog,
  input  wire logic [1:0]       wr_mode,
  input  wire logic             wr_cpol,
  input  wire logic             wr_cpha,
  input  wire logic             wr_lsb_first,
  output logic                  locked,
  output logic [14:0]           flags,
  output logic [7:0]            shadow_data,
  output logic [7:0]            nvm_data,
  output logic [TB_W-1:0]       tb_count,
  output logic [1:0]            if_mode,
  output logic                  spi_cpol,
  output logic                  spi_cpha,
  output logic                  spi_lsb_first,
  output logic                  irq_chipsel_pin_o,
  output logic                  irq_chipsel_pin_oe,
  output logic                  diag_active,
  output logic                  diag_level
);
  // Refuse widths that the counters and the flag vector cannot serve.
  if (TB_W < 4 || TB_W > $bits(dau_pkg::TB_RST)) begin : g_bad_tb_w
    $error("dau_top: TB_W outside the supported range");
  end

  if (WD_W < 1) begin : g_bad_wd_w
    $error("dau_top: WD_W must be at least 1");
  end

  if (dau_pkg::OSC_TIMEOUT_CYC >= 2 ** 16) begin : g_bad_timeout
    $error("dau_top: stuck timeout does not fit its counter");
  end

  if (dau_pkg::NFLAG != 15) begin : g_bad_nflag
    $error("dau_top: flag count does not match the flag ports");
  end

  logic [3:0]      async_in;
  logic [3:0]      sync_out;
  logic            ov_s;
  logic            uv_s;
  logic            crack_s;
  logic            osc_s;
  logic            osc_d;
  logic            osc_edge;
  logic            wr_ok;
  logic [14:0]     irq_en;
  logic            diag_en;
  logic [TB_W-1:0] tb_hi;
  logic [TB_W-1:0] tb_lo;
  logic [WD_W-1:0] wdog_val;
  logic [WD_W-1:0] wdog_cnt;
  logic            wdog_exp;
  logic [TB_W-1:0] win_cnt;
  logic [TB_W-1:0] edge_cnt;
  logic            win_end;
  logic            osc_range_err;
  logic [15:0]     stuck_cnt;
  logic            stuck_hit;
  logic            osc_stuck;
  logic            shd_sgl;
  logic            shd_dbl;
  logic            nvm_sgl;
  logic            nvm_dbl;
  logic [14:0]     cond;
  logic [14:0]     eval;
  logic            any_irq;

  assign async_in = {osc_in, crack, cmp_underv, cmp_overv};
  dau_sync #(
    .W (4)
  ) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .din  (async_in),
    .dout (sync_out)
  );
  assign ov_s = sync_out[0];
  assign uv_s = sync_out[1];
  assign crack_s = sync_out[2];
  assign osc_s = sync_out[3];

  // Shadow bank is checked every cycle and its output corrected.
  dau_secded u_shadow (
    .mclk       (mclk),
    .nrst       (nrst),
    .check      (1'b1),
    .code       (shadow_code),
    .data       (shadow_data),
    .single_err (shd_sgl),
    .double_err (shd_dbl)
  );
  // Each memory word read during start-up is checked and corrected.
  dau_secded u_nvm (
    .mclk       (mclk),
    .nrst       (nrst),
    .check      (startup && nvm_valid),
    .code       (nvm_code),
    .data       (nvm_data),
    .single_err (nvm_sgl),
    .double_err (nvm_dbl)
  );

  // Writes pass only while the lock is clear; reads are never gated.
  assign wr_ok = wr_req && !locked;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      locked <= 1'b0;
    end else if (wr_ok && lock_set) begin
      locked <= 1'b1;
    end
  end

  // Configuration registers take only accepted writes.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_en <= '0;
    end else if (wr_ok) begin
      irq_en <= wr_irq_en;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      diag_en <= 1'b0;
      diag_level <= 1'b0;
    end else if (wr_ok) begin
      diag_en <= wr_diag_en;
      diag_level <= wr_diag_lvl;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tb_hi <= '1;
      tb_lo <= '0;
    end else if (wr_ok) begin
      tb_hi <= wr_tb_hi;
      tb_lo <= wr_tb_lo;
    end
  end

  // Interface mode and SPI framing follow the last accepted write.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      if_mode <= 2'(dau_pkg::dau_i2c_addr);
    end else if (wr_ok) begin
      if_mode <= wr_mode;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      spi_cpol <= 1'b0;
      spi_cpha <= 1'b0;
      spi_lsb_first <= 1'b0;
    end else if (wr_ok) begin
      spi_cpol <= wr_cpol;
      spi_cpha <= wr_cpha;
      spi_lsb_first <= wr_lsb_first;
    end
  end

  // Watchdog: a nonzero value runs the counter, zero stops it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdog_val <= '0;
    end else if (wr_ok) begin
      wdog_val <= wr_wdog;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdog_cnt <= '0;
    end else if (wr_ok) begin
      wdog_cnt <= '0;
    end else if (wdog_val == '0) begin
      wdog_cnt <= '0;
    end else if (wdog_exp) begin
      wdog_cnt <= '0;
    end else begin
      wdog_cnt <= wdog_cnt + 1'b1;
    end
  end
  assign wdog_exp = wdog_val != '0 && wdog_cnt == wdog_val - 1'b1;

  // Time base: counts oscillator edges over a window of mclk cycles.
  assign osc_edge = osc_s && !osc_d;
  assign win_end = win_cnt >= tb_window;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      osc_d <= 1'b0;
    end else begin
      osc_d <= osc_s;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      win_cnt <= '0;
    end else if (win_end) begin
      win_cnt <= '0;
    end else begin
      win_cnt <= win_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      edge_cnt <= '0;
    end else if (win_end) begin
      edge_cnt <= '0;
    end else if (osc_edge && edge_cnt != '1) begin
      edge_cnt <= edge_cnt + 1'b1;
    end
  end

  // Window end latches the count and compares it with the limits.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tb_count <= dau_pkg::TB_RST[TB_W-1:0];
      osc_range_err <= 1'b0;
    end else if (win_end) begin
      tb_count <= edge_cnt;
      osc_range_err <= edge_cnt > tb_hi || edge_cnt < tb_lo;
    end
  end

  // Stuck detector: no oscillator edge for the timeout period.
  assign stuck_hit = stuck_cnt >= 16'(dau_pkg::OSC_TIMEOUT_CYC);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stuck_cnt <= '0;
    end else if (osc_edge) begin
      stuck_cnt <= '0;
    end else if (!stuck_hit) begin
      stuck_cnt <= stuck_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      osc_stuck <= 1'b0;
    end else begin
      osc_stuck <= !osc_edge && stuck_hit;
    end
  end

  // Raw fault conditions in flag order.
  always_comb begin
    cond = '0;
    cond[dau_pkg::F_OVERV] = ov_s;
    cond[dau_pkg::F_UNDERV] = uv_s;
    cond[dau_pkg::F_ACCESS] = access_fail;
    cond[dau_pkg::F_PROTO] = xfer_fail;
    cond[dau_pkg::F_SHD_DBL] = shd_dbl;
    cond[dau_pkg::F_SHD_SGL] = shd_sgl;
    cond[dau_pkg::F_NVM_DBL] = nvm_dbl;
    cond[dau_pkg::F_NVM_SGL] = nvm_sgl;
    cond[dau_pkg::F_OSC_RANGE] = osc_range_err;
    cond[dau_pkg::F_OSC_STUCK] = osc_stuck;
    cond[dau_pkg::F_ANALOG] = analog_low || pin_overv;
    cond[dau_pkg::F_LOWAMP] = incr_mode && amp_low;
    cond[dau_pkg::F_INTBUS] = intbus_fail;
    cond[dau_pkg::F_WDOG] = wdog_exp;
    cond[dau_pkg::F_CRACK] = crack_s;
  end

  // Start-up flags are only updated while the start-up sequence runs.
  assign eval = ~dau_pkg::STARTUP_MASK | {15{startup}};

  for (genvar i = 0; i < dau_pkg::NFLAG; i++) begin : g_flag
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        flags[i] <= dau_pkg::FLAGS_RST[i];
      end else if (eval[i]) begin
        if (dau_pkg::STATIC_MASK[i]) begin
          flags[i] <= flags[i] || cond[i];
        end else begin
          flags[i] <= cond[i];
        end
      end
    end
  end

  // Flags stay visible on the output whether or not writes are locked.
  assign any_irq = |(flags & irq_en);

  always_comb begin
    irq_chipsel_pin_oe = 1'b0;
    irq_chipsel_pin_o = 1'b1;
    unique case (dau_pkg::dau_mode_t'(if_mode))
      dau_pkg::dau_spi_irq, dau_pkg::dau_i2c_irq: begin
        irq_chipsel_pin_oe = 1'b1;
        irq_chipsel_pin_o = !any_irq;
      end
      dau_pkg::dau_spi_half, dau_pkg::dau_i2c_addr: begin
        irq_chipsel_pin_oe = 1'b0;
      end
    endcase
  end

  assign diag_active = diag_en && any_irq;
endmodule

// [testbench.sv]
/*
 Self-checking bench for dau_top with a host model on the write port.
 Assumes the 125 MHz clock and an oscillator input that the bench stops once for the stuck check.
*/
`timescale 1ns/1ps
module testbench;
  logic mclk = 0, nrst = 0, startup = 0, cmp_overv = 0, cmp_underv = 0;
  logic access_fail = 0, xfer_fail = 0, nvm_valid = 0, osc_in = 0;
  logic analog_low = 0, pin_overv = 0, incr_mode = 0, amp_low = 0;
  logic intbus_fail = 0, crack = 0, osc_run = 1;
  logic [12:0] shadow_code = 13'h0000, nvm_code = 13'h0000;
  logic [15:0] tb_window = 16'h000f, wr_tb_hi, wr_tb_lo, wr_wdog, tb_count;
  logic [14:0] wr_irq_en, flags;
  logic [7:0] shadow_data, nvm_data;
  logic [1:0] wr_mode, if_mode;
  logic wr_req, lock_set, wr_diag_en, wr_diag_lvl, wr_cpol, wr_cpha;
  logic wr_lsb_first, locked, spi_cpol, spi_cpha, spi_lsb_first;
  logic irq_chipsel_pin_o, irq_chipsel_pin_oe, diag_active, diag_level;
  int n_mismatch = 0, total_checks = 0;
  int srcs[8] = '{0, 1, 2, 3, 10, 11, 12, 15};
  int fidx[8] = '{0, 1, 2, 3, 10, 11, 12, 10};
  dau_top dut (
    .mclk               (mclk),
    .nrst               (nrst),
    .startup            (startup),
    .cmp_overv          (cmp_overv),
    .cmp_underv         (cmp_underv),
    .access_fail        (access_fail),
    .xfer_fail          (xfer_fail),
    .shadow_code        (shadow_code),
    .nvm_code           (nvm_code),
    .nvm_valid          (nvm_valid),
    .osc_in             (osc_in),
    .tb_window          (tb_window),
    .analog_low         (analog_low),
    .pin_overv          (pin_overv),
    .incr_mode          (incr_mode),
    .amp_low            (amp_low),
    .intbus_fail        (intbus_fail),
    .crack              (crack),
    .wr_req             (wr_req),
    .lock_set           (lock_set),
    .wr_irq_en          (wr_irq_en),
    .wr_diag_en         (wr_diag_en),
    .wr_diag_lvl        (wr_diag_lvl),
    .wr_tb_hi           (wr_tb_hi),
    .wr_tb_lo           (wr_tb_lo),
    .wr_wdog            (wr_wdog),
    .wr_mode            (wr_mode),
    .wr_cpol            (wr_cpol),
    .wr_cpha            (wr_cpha),
    .wr_lsb_first       (wr_lsb_first),
    .locked             (locked),
    .flags              (flags),
    .shadow_data        (shadow_data),
    .nvm_data           (nvm_data),
    .tb_count           (tb_count),
    .if_mode            (if_mode),
    .spi_cpol           (spi_cpol),
    .spi_cpha           (spi_cpha),
    .spi_lsb_first      (spi_lsb_first),
    .irq_chipsel_pin_o  (irq_chipsel_pin_o),
    .irq_chipsel_pin_oe (irq_chipsel_pin_oe),
    .diag_active        (diag_active),
    .diag_level         (diag_level)
  );
  dau_host host (
    .mclk         (mclk),
    .wr_req       (wr_req),
    .lock_set     (lock_set),
    .wr_irq_en    (wr_irq_en),
    .wr_diag_en   (wr_diag_en),
    .wr_diag_lvl  (wr_diag_lvl),
    .wr_tb_hi     (wr_tb_hi),
    .wr_tb_lo     (wr_tb_lo),
    .wr_wdog      (wr_wdog),
    .wr_mode      (wr_mode),
    .wr_cpol      (wr_cpol),
    .wr_cpha      (wr_cpha),
    .wr_lsb_first (wr_lsb_first)
  );
  always #4 mclk = ~mclk;
  always #21 if (osc_run) osc_in = ~osc_in;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task src(input int i, input logic v);
    case (i)
      0: cmp_overv = v;
      1: cmp_underv = v;
      2: access_fail = v;
      3: xfer_fail = v;
      10: analog_low = v;
      11: amp_low = v;
      12: intbus_fail = v;
      default: pin_overv = v;
    endcase
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    int n;
    step(6);
    nrst = 1;
    step(1);
    chk(flags, 0);
    chk(if_mode, 2);
    chk(irq_chipsel_pin_oe, 0);
    for (int m = 0; m < 4; m++) begin
      host.wr(m[1:0], 15'h7fff, 0, 0, 0);
      chk(if_mode, m);
      chk(diag_level, m & 1);
      chk(irq_chipsel_pin_oe, m & 1);
      chk({spi_lsb_first, spi_cpha, spi_cpol}, {^m[1:0], m[1:0]});
    end
    $display("test modes done");
    incr_mode = 1;
    foreach (srcs[k]) begin
      src(srcs[k], 1);
      step(6);
      chk(flags, 32'h1 << fidx[k]);
      chk({irq_chipsel_pin_o, diag_active, diag_level}, 3'h3);
      src(srcs[k], 0);
      step(6);
      chk(flags, 0);
      chk({irq_chipsel_pin_o, diag_active}, 2'h2);
    end
    host.wr(2'h3, 15'h7ff7, 0, 0, 0);
    xfer_fail = 1;
    step(2);
    chk(flags, 32'h8);
    chk({irq_chipsel_pin_o, diag_active}, 2'h2);
    xfer_fail = 0;
    $display("test temporary done");
    crack = 1;
    step(8);
    crack = 0;
    step(8);
    chk(flags[14], 1);
    chk(irq_chipsel_pin_o, 0);
    shadow_code = 13'h0008;
    step(4);
    chk({shadow_data, flags[5]}, 9'h001);
    shadow_code = 13'h0028;
    step(4);
    shadow_code = 13'h0000;
    step(4);
    chk(flags[5:4], 2'h1);
    nvm_valid = 1;
    nvm_code = 13'h0028;
    step(4);
    chk(flags[6], 0);
    startup = 1;
    nvm_code = 13'h0008;
    step(4);
    chk({nvm_data, flags[7]}, 9'h001);
    nvm_code = 13'h0028;
    step(4);
    startup = 0;
    nvm_code = 13'h0000;
    step(4);
    chk(flags[6], 1);
    $display("test static done");
    host.wr(2'h3, 15'h7fff, 16'd40, 0, 0);
    for (n = 0; n < 80 && flags[13] !== 1'b1; n++) step(1);
    chk(n >= 39 && n <= 41, 1);
    host.wr(2'h3, 15'h7fff, 0, 16'hffff, 0);
    step(60);
    chk(flags[8], 1);
    host.wr(2'h3, 15'h7fff, 0, 0, 0);
    step(60);
    chk(flags[8], 0);
    osc_run = 0;
    step(270);
    chk(flags[9], 1);
    osc_run = 1;
    step(60);
    chk(flags[9], 0);
    chk(tb_count >= 2 && tb_count <= 3, 1);
    $display("test monitors done");
    host.wr(2'h1, 15'h7fff, 0, 0, 1);
    chk({locked, if_mode}, 3'h5);
    host.wr(2'h2, 15'h7fff, 0, 0, 0);
    chk(if_mode, 1);
    chk(flags[14], 1);
    $display("test lock done");
    nrst = 0;
    step(2);
    nrst = 1;
    step(1);
    chk({locked, if_mode, flags}, 18'h10000);
    host.wr(2'h0, 15'h7fff, 0, 0, 0);
    chk(if_mode, 0);
    $display("test reset done");
    end_of_test;
  end
endmodule
bind dau_top dau_chk u_chk (
  .mclk               (mclk),
  .nrst               (nrst),
  .startup            (startup),
  .xfer_fail          (xfer_fail),
  .incr_mode          (incr_mode),
  .amp_low            (amp_low),
  .wr_req             (wr_req),
  .lock_set           (lock_set),
  .wr_mode            (wr_mode),
  .wr_cpol            (wr_cpol),
  .locked             (locked),
  .flags              (flags),
  .if_mode            (if_mode),
  .spi_cpol           (spi_cpol),
  .irq_chipsel_pin_o  (irq_chipsel_pin_o),
  .irq_chipsel_pin_oe (irq_chipsel_pin_oe),
  .diag_active        (diag_active)
);
